// ---- tb/csdf_msg_model.sv ----
`timescale 1ns/1ps
module csdf_msg_model (
	// Clock
	input  wire logic        i_clk,
	// Request from the block
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic        i_chan,
	input  wire logic        i_ext,
	input  wire logic [28:0] i_id,
	input  wire logic [63:0] i_wdata,
	// Payload answer
	output logic      [63:0] o_rdata
);
	logic [63:0] mem [logic [30:0]];
	logic [30:0] key;
	assign key = {i_chan, i_ext, i_id};
	initial o_rdata = 64'h0;
	// Payload stands one cycle only; toggling afterwards exposes a late sample
	always @(posedge i_clk) begin
		if (i_rd) begin
			o_rdata <= mem.exists(key) ? mem[key] : 64'h0;
		end else begin
			o_rdata <= ~o_rdata;
		end
		if (i_wr) begin
			mem[key] = i_wdata;
		end
	end
endmodule

// ---- tb/csdf_top_chk.sv ----
`timescale 1ns/1ps
module csdf_top_chk (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [31:0] o_rdata,
	// Message port and status
	input  wire logic        o_msg_rd,
	input  wire logic        o_msg_wr,
	input  wire logic        o_msg_ext,
	input  wire logic [28:0] o_msg_id,
	input  wire logic        o_busy
);
	logic cmd;
	logic sig_wr_q;
	assign cmd = i_wr && !o_busy && (i_addr == csdf_pkg::REG_CMD);
	// Write mode as the block holds it; writes while busy are dropped
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sig_wr_q <= 1'b0;
		end else if (i_wr && !o_busy && (i_addr == csdf_pkg::REG_SIG)) begin
			sig_wr_q <= i_wdata[csdf_pkg::SIG_WR_BIT];
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	property p_copy_req; cmd && (i_wdata[1:0] == csdf_pkg::OP_COPY) |=> o_msg_rd && o_busy; endproperty
	a_copy_req: assert property (p_copy_req) else $error("copy gave no request");
	property p_rd_done; o_msg_rd && !sig_wr_q |-> ##2 !o_busy && !o_msg_wr; endproperty
	a_rd_done: assert property (p_rd_done) else $error("read copy timing wrong");
	property p_wr_back; o_msg_rd && sig_wr_q |-> ##2 o_msg_wr ##1 !o_busy; endproperty
	a_wr_back: assert property (p_wr_back) else $error("write copy timing wrong");
	property p_wr_cause; o_msg_wr |-> $past(o_msg_rd, 2) && o_busy; endproperty
	a_wr_cause: assert property (p_wr_cause) else $error("stray write-back");
	property p_std_id; !o_msg_ext |-> (o_msg_id[28:11] == 18'h0); endproperty
	a_std_id: assert property (p_std_id) else $error("standard id too wide");
	property p_clear; cmd && (i_wdata[1:0] == csdf_pkg::OP_CLEAR) |=> o_busy[*8] ##72 o_busy ##1 !o_busy;
	endproperty
	a_clear: assert property (p_clear) else $error("clear length wrong");
	property p_text; cmd && (i_wdata[1:0] == csdf_pkg::OP_TEXT) |=> !o_busy; endproperty
	a_text: assert property (p_text) else $error("text start went busy");
	property p_show; cmd && (i_wdata[1:0] == csdf_pkg::OP_SHOW) |=> o_busy[*3]; endproperty
	a_show: assert property (p_show) else $error("show ended early");
	property p_stat; i_rd && (i_addr == csdf_pkg::REG_STAT) |=> o_rdata == {31'h0, $past(o_busy)}; endproperty
	a_stat: assert property (p_stat) else $error("status read wrong");
endmodule

bind csdf_top csdf_top_chk u_csdf_top_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_msg_rd(o_msg_rd),
	.o_msg_wr(o_msg_wr), .o_msg_ext(o_msg_ext), .o_msg_id(o_msg_id), .o_busy(o_busy));

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	logic i_clk, i_arst_n, i_wr, i_rd, o_msg_rd, o_msg_wr, o_msg_chan, o_msg_ext, o_busy;
	logic [7:0] i_addr, o_disp_char;
	logic [31:0] i_wdata, o_rdata, d;
	logic [28:0] o_msg_id;
	logic [63:0] o_msg_wdata, i_msg_rdata, pay;
	logic [6:0] i_disp_addr;
	int n_mismatch, n_tests, disp[80], pos, len, big, vi, f, al, col, row, flen, off, scl, v;
	bit [31:0] vars[16];
	bit [30:0] key;
	string s;
	csdf_top u_csdf_top (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_msg_rd(o_msg_rd), .o_msg_wr(o_msg_wr),
		.o_msg_chan(o_msg_chan), .o_msg_ext(o_msg_ext), .o_msg_id(o_msg_id),
		.o_msg_wdata(o_msg_wdata), .i_msg_rdata(i_msg_rdata), .i_disp_addr(i_disp_addr),
		.o_disp_char(o_disp_char), .o_busy(o_busy));
	csdf_msg_model u_csdf_msg_model (.i_clk(i_clk), .i_rd(o_msg_rd), .i_wr(o_msg_wr),
		.i_chan(o_msg_chan), .i_ext(o_msg_ext), .i_id(o_msg_id), .i_wdata(o_msg_wdata),
		.o_rdata(i_msg_rdata));
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	// ****************************************
	// Bus tasks and reference model
	// ****************************************
	task automatic summarize;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= w;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 r = o_rdata;
	endtask
	// Bounded wait; a hang is counted and ends the run
	task automatic run(input logic [1:0] op);
		int k;
		wr(csdf_pkg::REG_CMD, {30'h0, op});
		// Let the state register settle before busy is looked at
		#1;
		for (k = 0; k < 300 && o_busy !== 1'b0; k++) begin
			@(posedge i_clk);
			#1;
		end
		if (k == 300) begin
			n_mismatch++;
			summarize();
		end
	endtask
	function automatic int fbit(int p, int i, int bg);
		int b;
		int y;
		if (bg == 0) return (p + i < 64) ? p + i : -1;
		b = p % 8 + i;
		y = p / 8 - b / 8;
		return (y < 0) ? -1 : y * 8 + b % 8;
	endfunction
	function automatic void put(int c, int r, string t);
		for (int i = 0; i < t.len(); i++) begin
			if (c + i <= 20 && r >= 1 && r <= 4) disp[(r - 1) * 20 + c + i - 1] = t[i];
		end
	endfunction
	task automatic chk_disp;
		for (int a = 0; a < 80; a++) begin
			@(posedge i_clk);
			i_disp_addr <= a[6:0];
			@(posedge i_clk);
			#1 `CHK("display cell", disp[a][7:0], o_disp_char)
		end
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{i_arst_n, i_wr, i_rd, i_addr, i_wdata, i_disp_addr} = '0;
		void'($urandom(32'hf93c));
		repeat (6) @(posedge i_clk);
		i_arst_n <= 1'b1;
		rd(csdf_pkg::REG_POS, d);
		`CHK("pos reset", csdf_pkg::RST_POS, d)
		rd(csdf_pkg::REG_SIG, d);
		`CHK("sig reset", csdf_pkg::RST_SIG, d)
		rd(8'hF0, d);
		`CHK("unmapped", 32'h0, d)
		run(csdf_pkg::OP_CLEAR);
		rd(csdf_pkg::REG_STAT, d);
		`CHK("status", 32'h0, d)
		foreach (disp[i]) disp[i] = " ";
		// Text near the right edge: last character must be dropped
		wr(csdf_pkg::REG_POS, 32'd18 | (32'd2 << 5));
		run(csdf_pkg::OP_TEXT);
		s = "ABCD";
		for (int i = 0; i < 4; i++) wr(csdf_pkg::REG_TEXT, {24'h0, s[i]});
		put(18, 2, s);
		chk_disp();
		rd(csdf_pkg::REG_CUR, d);
		`CHK("cursor", 32'd21, d)
		for (int n = 0; n < 6; n++) begin
			pay = {$urandom, $urandom};
			v = $urandom;
			key = {v[0], v[1], v[1] ? v[30:2] : {18'h0, v[12:2]}};
			u_csdf_msg_model.mem[key] = pay;
			wr(csdf_pkg::REG_MSG, {1'b0, v[0], v[1], v[30:2]});
			pos = $urandom % 64;
			len = 1 + $urandom % 32;
			big = $urandom % 2;
			vi = $urandom % 16;
			wr(csdf_pkg::REG_SIG, (vi << 24) | (big << 16) | (len << 8) | pos);
			run(csdf_pkg::OP_COPY);
			vars[vi] = 0;
			for (int i = 0; i < len; i++) begin
				if (fbit(pos, i, big) >= 0) vars[vi][i] = pay[fbit(pos, i, big)];
			end
			rd(csdf_pkg::REG_VAR, d);
			`CHK("variable", vars[vi], d)
			pos = $urandom % 64;
			len = 1 + $urandom % 32;
			big = $urandom % 2;
			wr(csdf_pkg::REG_SIG, (vi << 24) | (1 << 17) | (big << 16) | (len << 8) | pos);
			run(csdf_pkg::OP_COPY);
			for (int i = 0; i < len; i++) begin
				if (fbit(pos, i, big) >= 0) pay[fbit(pos, i, big)] = vars[vi][i];
			end
			`CHK("payload", pay, u_csdf_msg_model.mem[key])
		end
		// Every format and alignment, both signs of scale
		for (int k = 0; k < 8; k++) begin
			f = k % 4;
			al = k / 4;
			col = 1 + $urandom % 20;
			row = 1 + $urandom % 4;
			flen = $urandom % 13;
			off = $urandom % 200 - 100;
			// Sign of scale alternates so each format sees both formulas
			scl = ((k + k / 4) % 2) ? -int'(1 + $urandom % 5) : int'($urandom % 6);
			wr(csdf_pkg::REG_OFF, off);
			wr(csdf_pkg::REG_SCL, scl);
			wr(csdf_pkg::REG_POS, col | (row << 5) | (flen << 8) | (f << 16) | (al << 18));
			run(csdf_pkg::OP_SHOW);
			v = int'(vars[vi]) - off;
			v = (scl >= 0) ? v * scl : v / (-scl);
			if (f == 0) s = $sformatf("%s%0d", (v < 0) ? "-" : "+", (v < 0) ? -longint'(v) : v);
			else if (f == 2) s = $sformatf("%0h", v);
			else s = $sformatf("%0d", unsigned'(v));
			s = s.toupper();
			while (s.len() < flen) s = (al == 1) ? {s, " "} : {" ", s};
			put(col, row, s);
			chk_disp();
		end
		summarize();
	end
endmodule

// ---- verilog/csdf_numfmt.sv ----
`timescale 1ns/1ps
module csdf_numfmt (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// Request
	input  wire logic        i_start,
	input  wire logic [31:0] i_value,
	input  wire logic [1:0]  i_fmt,
	// Result, slot 0 is the rightmost character
	output logic             o_done,
	output logic      [3:0]  o_len,
	output logic      [95:0] o_chars
);

	csdf_pkg::csdf_nf_t st_reg, st_next;
	logic [31:0] work_reg, work_next;
	logic        neg_reg, neg_next;
	logic        sgn_reg, sgn_next;
	logic        hex_reg, hex_next;
	logic [3:0]  len_reg, len_next;
	logic [95:0] chars_reg, chars_next;
	logic        done_reg, done_next;
	logic [3:0]  digit;
	logic [31:0] rest;

	// ********************************************
	// One digit per cycle, least significant first
	// ********************************************
	always_comb begin
		st_next = st_reg;
		work_next = work_reg;
		neg_next = neg_reg;
		sgn_next = sgn_reg;
		hex_next = hex_reg;
		len_next = len_reg;
		chars_next = chars_reg;
		done_next = 1'b0;
		digit = hex_reg ? work_reg[3:0] : 4'(work_reg % 32'h0000_000A);
		rest = hex_reg ? (work_reg >> 4) : (work_reg / 32'h0000_000A);
		case (st_reg)
			csdf_pkg::NF_IDLE: begin
				if (i_start) begin
					sgn_next = (i_fmt == csdf_pkg::FMT_SIGNED);
					hex_next = (i_fmt == csdf_pkg::FMT_HEX);
					neg_next = sgn_next && i_value[31];
					work_next = neg_next ? (32'h0 - i_value) : i_value;
					len_next = 4'h0;
					chars_next = '0;
					st_next = csdf_pkg::NF_RUN;
				end
			end
			csdf_pkg::NF_RUN: begin
				chars_next[{len_reg, 3'b000} +: 8] = (digit > 4'h9)
					? (csdf_pkg::CH_HEXA + {4'h0, digit})
					: (csdf_pkg::CH_ZERO + {4'h0, digit});
				len_next = len_reg + 4'h1;
				work_next = rest;
				if (rest == 32'h0) begin
					if (sgn_reg) begin
						chars_next[{len_next, 3'b000} +: 8] = neg_reg
							? csdf_pkg::CH_MINUS : csdf_pkg::CH_PLUS;
						len_next = len_reg + 4'h2;
					end
					done_next = 1'b1;
					st_next = csdf_pkg::NF_IDLE;
				end
			end
			default: begin
				st_next = csdf_pkg::NF_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg <= csdf_pkg::NF_IDLE;
			work_reg <= '0;
			neg_reg <= 1'b0;
			sgn_reg <= 1'b0;
			hex_reg <= 1'b0;
			len_reg <= '0;
			chars_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			work_reg <= work_next;
			neg_reg <= neg_next;
			sgn_reg <= sgn_next;
			hex_reg <= hex_next;
			len_reg <= len_next;
			chars_reg <= chars_next;
			done_reg <= done_next;
		end
	end

	assign o_done = done_reg;
	assign o_len = len_reg;
	assign o_chars = chars_reg;

endmodule

// ---- verilog/csdf_pkg.sv ----
// Overview of operation
// - Display holds four rows of twenty cells
// - Column 1..20, row 1..4, top-left origin
// - Text goes in from the configured position
// - Signal: channel, identifier, format, position, length
// - Read mode stores field into a variable
// - Write mode stores variable into the field
// - Field copied unsigned, never sign extended
// - Flag chooses big or little byte order
// - Position names the LSB, per byte order
// - Copy then show are two separate actions
// - Show writes variable at position, reserving cells
// - Format: signed with sign, unsigned, hexadecimal
// - Value left or right aligned in field
// - Positive scale: (value minus offset) times scale
// - Negative scale: (value minus offset) over magnitude
// - Overlong values spill past the field end
// - Format flag: 29-bit extended, 11-bit standard
// - Actions run one by one in order
package csdf_pkg;

	// ********************************************
	// Display geometry
	// ********************************************
	localparam logic [5:0] COLS  = 6'h14;
	localparam logic [2:0] ROWS  = 3'h4;
	localparam logic [6:0] CELLS = 7'h50;

	// ********************************************
	// Register offsets
	// ********************************************
	localparam logic [7:0] REG_CMD  = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_POS  = 8'h08;
	localparam logic [7:0] REG_MSG  = 8'h0C;
	localparam logic [7:0] REG_SIG  = 8'h10;
	localparam logic [7:0] REG_OFF  = 8'h14;
	localparam logic [7:0] REG_SCL  = 8'h18;
	localparam logic [7:0] REG_TEXT = 8'h1C;
	localparam logic [7:0] REG_VAR  = 8'h20;
	localparam logic [7:0] REG_CUR  = 8'h24;

	// ********************************************
	// Field positions
	// ********************************************
	localparam int POS_COL_LSB  = 0;
	localparam int POS_ROW_LSB  = 5;
	localparam int POS_FLEN_LSB = 8;
	localparam int POS_FMT_LSB  = 16;
	localparam int POS_LEFT_BIT = 18;
	localparam int MSG_EXT_BIT  = 29;
	localparam int MSG_CHAN_BIT = 30;
	localparam int SIG_POS_LSB  = 0;
	localparam int SIG_LEN_LSB  = 8;
	localparam int SIG_BIG_BIT  = 16;
	localparam int SIG_WR_BIT   = 17;
	localparam int SIG_VAR_LSB  = 24;
	localparam int STAT_BUSY    = 0;

	// ********************************************
	// Reset values and encodings
	// ********************************************
	localparam logic [31:0] RST_POS = 32'h0000_0021;
	localparam logic [31:0] RST_MSG = 32'h0000_0000;
	localparam logic [31:0] RST_SIG = 32'h0000_0100;
	localparam logic [31:0] RST_OFF = 32'h0000_0000;
	localparam logic [31:0] RST_SCL = 32'h0000_0001;
	localparam logic [1:0]  OP_TEXT  = 2'h0;
	localparam logic [1:0]  OP_COPY  = 2'h1;
	localparam logic [1:0]  OP_SHOW  = 2'h2;
	localparam logic [1:0]  OP_CLEAR = 2'h3;
	localparam logic [1:0]  FMT_SIGNED = 2'h0;
	localparam logic [1:0]  FMT_HEX    = 2'h2;
	localparam logic [7:0]  CH_SPACE = 8'h20;
	localparam logic [7:0]  CH_PLUS  = 8'h2B;
	localparam logic [7:0]  CH_MINUS = 8'h2D;
	localparam logic [7:0]  CH_ZERO  = 8'h30;
	localparam logic [7:0]  CH_HEXA  = 8'h37;

	typedef enum {ST_IDLE, ST_MSG_RD, ST_COPY, ST_MSG_WR, ST_SCALE, ST_FMT, ST_FWAIT,
		ST_PUT, ST_CLR} csdf_eng_t;
	typedef enum {NF_IDLE, NF_RUN} csdf_nf_t;

endpackage

// ---- verilog/csdf_ram.sv ----
`timescale 1ns/1ps
module csdf_ram #(
	parameter int W  = 8,
	parameter int D  = 80,
	parameter int AW = 7
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_arst_n,
	// Write port
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [W-1:0]  i_wdata,
	// Read port
	input  wire logic [AW-1:0] i_raddr,
	output logic      [W-1:0]  o_rdata
);

	logic [W-1:0] mem [D];
	logic [W-1:0] rdata_reg;
	logic [W-1:0] rdata_next;

	// ********************************************
	// Storage, no reset so it maps onto block memory
	// ********************************************
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_comb begin
		rdata_next = mem[i_raddr];
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign o_rdata = rdata_reg;

endmodule

// ---- verilog/csdf_top.sv ----
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module csdf_top (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// Stored message access
	output logic             o_msg_rd,
	output logic             o_msg_wr,
	output logic             o_msg_chan,
	output logic             o_msg_ext,
	output logic      [28:0] o_msg_id,
	output logic      [63:0] o_msg_wdata,
	input  wire logic [63:0] i_msg_rdata,
	// Display refresh port
	input  wire logic [6:0]  i_disp_addr,
	output logic      [7:0]  o_disp_char,
	// Status
	output logic             o_busy
);

	// ********************************************
	// Helpers
	// ********************************************
	function automatic logic [63:0] swap_bytes(input logic [63:0] d);
		logic [63:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i*8 +: 8] = d[(7-i)*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic cell_ok(input logic [5:0] col, input logic [2:0] row);
		return (col >= 6'h01) && (col <= csdf_pkg::COLS)
			&& (row >= 3'h1) && (row <= csdf_pkg::ROWS);
	endfunction

	function automatic logic [6:0] cell_addr(input logic [5:0] col, input logic [2:0] row);
		return 7'(({4'h0, row} - 7'h01) * 7'h14 + {1'b0, col} - 7'h01);
	endfunction

	function automatic logic [7:0] char_at(input logic [95:0] c, input logic [3:0] n);
		return c[{n, 3'b000} +: 8];
	endfunction

	// ********************************************
	// Configuration registers
	// ********************************************
	logic [31:0] pos_reg, pos_next;
	logic [31:0] msg_reg, msg_next;
	logic [31:0] sig_reg, sig_next;
	logic [31:0] off_reg, off_next;
	logic [31:0] scl_reg, scl_next;
	logic [5:0]  cur_reg, cur_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        rvar_reg, rvar_next;

	logic [4:0] p_col;
	logic [2:0] p_row;
	logic [4:0] p_flen;
	logic [1:0] p_fmt;
	logic       p_left;
	logic [5:0] s_pos;
	logic [5:0] s_len;
	logic       s_big;
	logic       s_wr;
	logic [3:0] s_var;
	logic       idle;
	logic       cmd_go;

	csdf_pkg::csdf_eng_t st_reg, st_next;

	assign p_col = pos_reg[csdf_pkg::POS_COL_LSB +: 5];
	assign p_row = pos_reg[csdf_pkg::POS_ROW_LSB +: 3];
	assign p_flen = pos_reg[csdf_pkg::POS_FLEN_LSB +: 5];
	assign p_fmt = pos_reg[csdf_pkg::POS_FMT_LSB +: 2];
	assign p_left = pos_reg[csdf_pkg::POS_LEFT_BIT];
	assign s_pos = sig_reg[csdf_pkg::SIG_POS_LSB +: 6];
	assign s_len = sig_reg[csdf_pkg::SIG_LEN_LSB +: 6];
	assign s_big = sig_reg[csdf_pkg::SIG_BIG_BIT];
	assign s_wr = sig_reg[csdf_pkg::SIG_WR_BIT];
	assign s_var = sig_reg[csdf_pkg::SIG_VAR_LSB +: 4];
	assign idle = (st_reg == csdf_pkg::ST_IDLE);
	assign cmd_go = i_wr && (i_addr == csdf_pkg::REG_CMD) && idle;

	logic [31:0] var_q;

	// Operands are frozen while an action runs so it sees one consistent set
	always_comb begin
		pos_next = pos_reg;
		msg_next = msg_reg;
		sig_next = sig_reg;
		off_next = off_reg;
		scl_next = scl_reg;
		cur_next = cur_reg;
		if (i_wr && idle) begin
			case (i_addr)
				csdf_pkg::REG_POS: begin
					pos_next = i_wdata;
					cur_next = {1'b0, i_wdata[csdf_pkg::POS_COL_LSB +: 5]};
				end
				csdf_pkg::REG_MSG: begin
					msg_next = i_wdata;
					if (!i_wdata[csdf_pkg::MSG_EXT_BIT]) begin
						msg_next[28:11] = '0;
					end
				end
				csdf_pkg::REG_SIG: sig_next = i_wdata;
				csdf_pkg::REG_OFF: off_next = i_wdata;
				csdf_pkg::REG_SCL: scl_next = i_wdata;
				csdf_pkg::REG_TEXT: begin
					if (cur_reg <= csdf_pkg::COLS) begin
						cur_next = cur_reg + 6'h01;
					end
				end
				csdf_pkg::REG_CMD: begin
					if (i_wdata[1:0] == csdf_pkg::OP_TEXT) begin
						cur_next = {1'b0, p_col};
					end
				end
				default: cur_next = cur_reg;
			endcase
		end
		rvar_next = i_rd && (i_addr == csdf_pkg::REG_VAR);
		rdata_next = '0;
		if (i_rd) begin
			case (i_addr)
				csdf_pkg::REG_STAT: rdata_next[csdf_pkg::STAT_BUSY] = !idle;
				csdf_pkg::REG_POS: rdata_next = pos_reg;
				csdf_pkg::REG_MSG: rdata_next = msg_reg;
				csdf_pkg::REG_SIG: rdata_next = sig_reg;
				csdf_pkg::REG_OFF: rdata_next = off_reg;
				csdf_pkg::REG_SCL: rdata_next = scl_reg;
				csdf_pkg::REG_CUR: rdata_next = {26'h0, cur_reg};
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pos_reg <= csdf_pkg::RST_POS;
			msg_reg <= csdf_pkg::RST_MSG;
			sig_reg <= csdf_pkg::RST_SIG;
			off_reg <= csdf_pkg::RST_OFF;
			scl_reg <= csdf_pkg::RST_SCL;
			cur_reg <= 6'h01;
			rdata_reg <= '0;
			rvar_reg <= 1'b0;
		end else begin
			pos_reg <= pos_next;
			msg_reg <= msg_next;
			sig_reg <= sig_next;
			off_reg <= off_next;
			scl_reg <= scl_next;
			cur_reg <= cur_next;
			rdata_reg <= rdata_next;
			rvar_reg <= rvar_next;
		end
	end

	assign o_rdata = rvar_reg ? var_q : rdata_reg;

	// ********************************************
	// Action engine
	// ********************************************
	logic [6:0]  cnt_reg, cnt_next;
	logic [31:0] val_reg, val_next;
	logic [63:0] wdat_reg, wdat_next;
	logic        fmt_start;
	logic        fmt_done;
	logic [3:0]  fmt_len;
	logic [95:0] fmt_chars;
	logic [63:0] lane;
	logic [63:0] mask;
	logic [5:0]  ppos;
	logic [63:0] merged;
	logic [31:0] field;
	logic [31:0] diff;
	logic        var_we;
	logic        disp_we;
	logic [6:0]  disp_wa;
	logic [7:0]  disp_wd;
	logic [5:0]  total;
	logic [5:0]  pad;
	logic [5:0]  k;
	logic [5:0]  col;
	logic [7:0]  ch;

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		val_next = val_reg;
		wdat_next = wdat_reg;
		fmt_start = 1'b0;
		var_we = 1'b0;
		disp_we = 1'b0;
		disp_wa = cell_addr(cur_reg, p_row);
		disp_wd = i_wdata[7:0];
		// Big order walks bytes downward; swapping makes the field contiguous
		lane = s_big ? swap_bytes(i_msg_rdata) : i_msg_rdata;
		ppos = s_big ? {~s_pos[5:3], s_pos[2:0]} : s_pos;
		mask = ((64'h1 << s_len) - 64'h1) & 64'h0000_0000_FFFF_FFFF;
		field = 32'((lane >> ppos) & mask);
		merged = (lane & ~(mask << ppos)) | (({32'h0, var_q} & mask) << ppos);
		diff = var_q - off_reg;
		k = cnt_reg[5:0];
		total = ({1'b0, p_flen} > {2'h0, fmt_len}) ? {1'b0, p_flen} : {2'h0, fmt_len};
		pad = {1'b0, p_flen} - {2'h0, fmt_len};
		if (p_left) begin
			ch = (k < {2'h0, fmt_len}) ? char_at(fmt_chars, 4'(fmt_len - 4'(k) - 4'h1))
				: csdf_pkg::CH_SPACE;
		end else if (total != {2'h0, fmt_len} && k < pad) begin
			ch = csdf_pkg::CH_SPACE;
		end else begin
			ch = char_at(fmt_chars, 4'(total - k - 6'h01));
		end
		col = {1'b0, p_col} + k;
		case (st_reg)
			csdf_pkg::ST_IDLE: begin
				if (i_wr && i_addr == csdf_pkg::REG_TEXT) begin
					disp_we = cell_ok(cur_reg, p_row);
				end
				if (cmd_go) begin
					cnt_next = '0;
					case (i_wdata[1:0])
						csdf_pkg::OP_COPY: st_next = csdf_pkg::ST_MSG_RD;
						csdf_pkg::OP_SHOW: st_next = csdf_pkg::ST_SCALE;
						csdf_pkg::OP_CLEAR: st_next = csdf_pkg::ST_CLR;
						default: st_next = csdf_pkg::ST_IDLE;
					endcase
				end
			end
			csdf_pkg::ST_MSG_RD: st_next = csdf_pkg::ST_COPY;
			csdf_pkg::ST_COPY: begin
				if (s_wr) begin
					wdat_next = s_big ? swap_bytes(merged) : merged;
					st_next = csdf_pkg::ST_MSG_WR;
				end else begin
					var_we = 1'b1;
					st_next = csdf_pkg::ST_IDLE;
				end
			end
			csdf_pkg::ST_MSG_WR: st_next = csdf_pkg::ST_IDLE;
			csdf_pkg::ST_SCALE: begin
				if (scl_reg[31]) begin
					val_next = 32'($signed(diff) / (-$signed(scl_reg)));
				end else begin
					val_next = 32'($signed(diff) * $signed(scl_reg));
				end
				st_next = csdf_pkg::ST_FMT;
			end
			csdf_pkg::ST_FMT: begin
				fmt_start = 1'b1;
				st_next = csdf_pkg::ST_FWAIT;
			end
			csdf_pkg::ST_FWAIT: begin
				if (fmt_done) begin
					st_next = csdf_pkg::ST_PUT;
				end
			end
			csdf_pkg::ST_PUT: begin
				disp_we = cell_ok(col, p_row);
				disp_wa = cell_addr(col, p_row);
				disp_wd = ch;
				cnt_next = cnt_reg + 7'h01;
				if (k + 6'h01 >= total) begin
					st_next = csdf_pkg::ST_IDLE;
				end
			end
			csdf_pkg::ST_CLR: begin
				disp_we = 1'b1;
				disp_wa = cnt_reg;
				disp_wd = csdf_pkg::CH_SPACE;
				cnt_next = cnt_reg + 7'h01;
				if (cnt_reg == csdf_pkg::CELLS - 7'h01) begin
					st_next = csdf_pkg::ST_IDLE;
				end
			end
			default: st_next = csdf_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg <= csdf_pkg::ST_IDLE;
			cnt_reg <= '0;
			val_reg <= '0;
			wdat_reg <= '0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			val_reg <= val_next;
			wdat_reg <= wdat_next;
		end
	end

	assign o_msg_rd = (st_reg == csdf_pkg::ST_MSG_RD);
	assign o_msg_wr = (st_reg == csdf_pkg::ST_MSG_WR);
	assign o_msg_chan = msg_reg[csdf_pkg::MSG_CHAN_BIT];
	assign o_msg_ext = msg_reg[csdf_pkg::MSG_EXT_BIT];
	assign o_msg_id = msg_reg[28:0];
	assign o_msg_wdata = wdat_reg;
	assign o_busy = !idle;

	// ********************************************
	// Submodules
	// ********************************************
	csdf_ram #(.W(32), .D(16), .AW(4)) u_vars (
		.i_clk   (i_clk),
		.i_arst_n(i_arst_n),
		.i_we    (var_we),
		.i_waddr (s_var),
		.i_wdata (field),
		.i_raddr (s_var),
		.o_rdata (var_q)
	);

	csdf_ram #(.W(8), .D(80), .AW(7)) u_disp (
		.i_clk   (i_clk),
		.i_arst_n(i_arst_n),
		.i_we    (disp_we),
		.i_waddr (disp_wa),
		.i_wdata (disp_wd),
		.i_raddr (i_disp_addr),
		.o_rdata (o_disp_char)
	);

	csdf_numfmt u_fmt (
		.i_clk   (i_clk),
		.i_arst_n(i_arst_n),
		.i_start (fmt_start),
		.i_value (val_reg),
		.i_fmt   (p_fmt),
		.o_done  (fmt_done),
		.o_len   (fmt_len),
		.o_chars (fmt_chars)
	);

endmodule
